// file: dv/tcc_counter_model.sv
// Surrounding timer model: free-running counter and external tick source
`timescale 1ns/1ps
`default_nettype none
module tcc_counter_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic tick_i,
  input wire logic load_i,
  input wire logic [15:0] load_value_i,
  input wire logic ext_run_i,
  output logic [15:0] counter_o,
  output logic ext_tick_o
);
  logic [1:0] div_q;
  // Counter reloads on a trigger, else counts on each timer tick
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      counter_o <= 16'hfffc;
      div_q <= 2'h0;
      ext_tick_o <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      // Ticks four clocks apart, the fastest the block may be fed
      ext_tick_o <= ext_run_i && (div_q == 2'h3);
      if (load_i) begin
        counter_o <= load_value_i;
      end else if (tick_i) begin
        counter_o <= counter_o + 16'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/timer_capture_compare_one_pulse_bench.sv
// Self-checking bench for the timer capture/compare block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; $display("BAD %s exp %h got %h", nm, e, g); end end
module timer_capture_compare_one_pulse_bench;
  import tcc_pkg::*;
  typedef struct packed {logic [7:0] e; logic [7:0] m;} tcc_note_type;
  logic clk_i = 0, reset_n_i = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, ext_tick, tick, ld, irq, mask = 1, ext_run = 0;
  logic halt = 0;
  logic [1:0] cap_pin = 2'b11, cmp_pin, cmp_en;
  logic [15:0] counter, ld_val, c;
  logic [7:0] r;
  int mismatches = 0, num_checks = 0, seed = 37, loads = 0, hi_cycles = 0;
  int h;
  tcc_note_type notes[$];
  tcc_note_type n;
  initial forever #12.5 clk_i = ~clk_i;
  tcc_timer_cc i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .counter_i(counter), .ext_tick_i(ext_tick),
    .halt_i(halt), .cpu_irq_mask_i(mask), .capture_pin_i(cap_pin),
    .compare_pin_o(cmp_pin), .compare_pin_enable_o(cmp_en),
    .timer_tick_o(tick), .counter_load_o(ld),
    .counter_load_value_o(ld_val), .irq_o(irq));
  tcc_counter_model i_model (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .tick_i(tick), .load_i(ld), .load_value_i(ld_val), .ext_run_i(ext_run),
    .counter_o(counter), .ext_tick_o(ext_tick));
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_i);
    penable <= 1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 50);
    psel <= 0;
    penable <= 0;
    if (k >= 50) begin
      mismatches++;
      results;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  // Note the expectation first, the monitor pops it at the access edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    notes.push_back('{e, m});
    xfer(1'b0, a, 8'h00);
  endtask
  task automatic pin(input int b, input logic v);
    @(posedge clk_i);
    cap_pin[b] <= v;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic wait_pin(input int b, input logic v);
    int k;
    k = 0;
    while (cmp_pin[b] !== v && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 3000) begin
      mismatches++;
      $display("BAD pin%0d exp %b got %b", b, v, cmp_pin[b]);
      results;
    end
  endtask
  // Read monitor; also counts counter loads and high pin cycles
  always @(posedge clk_i) begin
    if (ld === 1'b1) loads++;
    if (cmp_pin[0] === 1'b1) hi_cycles++;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (notes.size() == 0) begin
        mismatches++;
        $display("BAD read exp note got none");
      end else begin
        n = notes.pop_front();
        `CHK("read", n.e & n.m, prdata[7:0] & n.m)
      end
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    `CHK("pins", 2'b00, cmp_pin)
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1;
    rd(ADDR_CTRL1, 8'h00, 8'hff);
    rd(ADDR_STATUS, 8'h00, 8'hd8);
    rd(ADDR_CMP1_HI, 8'h80, 8'hff);
    rd(ADDR_CMP1_LO, 8'h00, 8'hff);
    rd(ADDR_CMP2_HI, 8'h80, 8'hff);
    rd(8'h30, 8'h00, 8'hff);
    repeat (4) begin
      r = $random(seed);
      wr(ADDR_CMP2_HI, r);
      wr(ADDR_CMP2_LO, ~r);
      rd(ADDR_CMP2_HI, r, 8'hff);
      rd(ADDR_CMP2_LO, ~r, 8'hff);
    end
    // Capture with a frozen counter so the value is exact
    wr(ADDR_CTRL2, 8'h0c);
    wr(ADDR_CTRL1, 8'h82);
    pin(0, 0);
    c = counter;
    rd(ADDR_STATUS, 8'h00, 8'h80);
    pin(0, 1);
    pin(1, 0);
    rd(ADDR_STATUS, 8'h90, 8'h90);
    `CHK("irq masked", 1'b0, irq)
    mask <= 0;
    repeat (2) @(posedge clk_i);
    `CHK("irq", 1'b1, irq)
    mask <= 1;
    rd(ADDR_CAP1_HI, c[15:8], 8'hff);
    rd(ADDR_CAP1_LO, c[7:0], 8'hff);
    rd(ADDR_STATUS, 8'h10, 8'h90);
    wr(ADDR_CAP2_HI, ~c[15:8]);
    rd(ADDR_CAP2_HI, c[15:8], 8'hff);
    ext_run <= 1;
    repeat (40) @(posedge clk_i);
    ext_run <= 0;
    repeat (4) @(posedge clk_i);
    pin(1, 1);
    pin(1, 0);
    rd(ADDR_CAP2_LO, c[7:0], 8'hff);
    c = counter;
    pin(1, 1);
    pin(1, 0);
    rd(ADDR_CAP2_HI, c[15:8], 8'hff);
    rd(ADDR_CAP2_LO, c[7:0], 8'hff);
    // Halt: edges only arm, first edge data shows on wake
    rd(ADDR_STATUS, 8'h10, 8'h10);
    rd(ADDR_CAP2_LO, c[7:0], 8'hff);
    halt <= 1;
    @(posedge clk_i);
    c = counter;
    pin(1, 1);
    pin(1, 0);
    rd(ADDR_STATUS, 8'h00, 8'h10);
    ext_run <= 1;
    repeat (12) @(posedge clk_i);
    ext_run <= 0;
    repeat (4) @(posedge clk_i);
    pin(1, 1);
    pin(1, 0);
    halt <= 0;
    repeat (2) @(posedge clk_i);
    rd(ADDR_STATUS, 8'h10, 8'h10);
    rd(ADDR_CAP2_HI, c[15:8], 8'hff);
    rd(ADDR_CAP2_LO, c[7:0], 8'hff);
    // Compare two with the advised high, status, low order
    wr(ADDR_CTRL2, 8'h44);
    wr(ADDR_CTRL1, 8'h44);
    c = counter + 16'h0030;
    wr(ADDR_CMP2_HI, c[15:8]);
    rd(ADDR_STATUS, 8'h00, 8'h00);
    wr(ADDR_CMP2_LO, c[7:0]);
    wait_pin(1, 1'b1);
    `CHK("irq masked", 1'b0, irq)
    rd(ADDR_STATUS, 8'h08, 8'h08);
    mask <= 0;
    repeat (2) @(posedge clk_i);
    `CHK("irq", 1'b1, irq)
    mask <= 1;
    wr(ADDR_CMP2_LO, c[7:0]);
    rd(ADDR_STATUS, 8'h00, 8'h08);
    // One pulse: force ignored, trigger, pulse end
    wr(ADDR_CMP1_HI, 8'h00);
    wr(ADDR_CMP1_LO, 8'h10);
    wr(ADDR_CTRL2, 8'ha4);
    wr(ADDR_CTRL1, 8'h0f);
    repeat (4) @(posedge clk_i);
    `CHK("force opm", 1'b0, cmp_pin[0])
    wr(ADDR_CTRL1, 8'h06);
    h = loads;
    pin(0, 0);
    pin(0, 1);
    wait_pin(0, 1'b1);
    `CHK("loads", h + 1, loads)
    wait_pin(0, 1'b0);
    rd(ADDR_STATUS, 8'h80, 8'hc0);
    rd(ADDR_CAP1_HI, 8'hff, 8'hff);
    rd(ADDR_CAP1_LO, 8'hfd, 8'hff);
    rd(ADDR_STATUS, 8'h00, 8'h80);
    wr(ADDR_CTRL1, 8'h02);
    h = hi_cycles;
    pin(0, 0);
    pin(0, 1);
    repeat (80) @(posedge clk_i);
    `CHK("flat pin", h, hi_cycles)
    // Force outside one pulse mode
    wr(ADDR_CTRL2, 8'h84);
    wr(ADDR_CTRL1, 8'h09);
    repeat (4) @(posedge clk_i);
    `CHK("force", 1'b1, cmp_pin[0])
    rd(ADDR_STATUS, 8'h00, 8'h40);
    repeat (2) @(posedge clk_i);
    results;
  end
endmodule
`default_nettype wire

// file: inc/tcc_pkg.sv
// Package for the timer capture/compare and one pulse block
package tcc_pkg;
  // Register word offsets on APB (byte addresses)
  localparam logic [7:0] ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] ADDR_CTRL2 = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CAP1_HI = 8'h0c;
  localparam logic [7:0] ADDR_CAP1_LO = 8'h10;
  localparam logic [7:0] ADDR_CAP2_HI = 8'h14;
  localparam logic [7:0] ADDR_CAP2_LO = 8'h18;
  localparam logic [7:0] ADDR_CMP1_HI = 8'h1c;
  localparam logic [7:0] ADDR_CMP1_LO = 8'h20;
  localparam logic [7:0] ADDR_CMP2_HI = 8'h24;
  localparam logic [7:0] ADDR_CMP2_LO = 8'h28;
  localparam logic [7:0] ADDR_MISC = 8'h2c;
  // Control one fields
  localparam int C1_CAP_IE = 7;
  localparam int C1_CMP_IE = 6;
  localparam int C1_FORCE2 = 4;
  localparam int C1_FORCE1 = 3;
  localparam int C1_LVL2 = 2;
  localparam int C1_EDGE1 = 1;
  localparam int C1_LVL1 = 0;
  // Control two fields
  localparam int C2_PIN_EN1 = 7;
  localparam int C2_PIN_EN2 = 6;
  localparam int C2_ONE_PULSE = 5;
  localparam int C2_PWM = 4;
  localparam int C2_CLK_HI = 3;
  localparam int C2_CLK_LO = 2;
  localparam int C2_EDGE2 = 1;
  // Status fields
  localparam int ST_CAP1 = 7;
  localparam int ST_CMP1 = 6;
  localparam int ST_CAP2 = 4;
  localparam int ST_CMP2 = 3;
  // Reset and load values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [15:0] CNT_TRIGGER = 16'hfffc;
  localparam logic [15:0] CAP_TRIGGER = 16'hfffd;
  // Prescaler selections
  localparam logic [1:0] CLK_DIV4 = 2'b00;
  localparam logic [1:0] CLK_DIV2 = 2'b01;
  localparam logic [1:0] CLK_DIV8 = 2'b10;
  localparam logic [1:0] CLK_EXT = 2'b11;
  localparam logic [2:0] DIV4_MASK = 3'h3;
  localparam logic [2:0] DIV2_MASK = 3'h1;
  localparam logic [2:0] DIV8_MASK = 3'h7;
  // Bundled per-channel capture state
  typedef struct packed {
    logic [15:0] value;
    logic flag;
    logic armed;
    logic [15:0] halt_value;
    logic locked;
  } tcc_cap_type;
endpackage

// file: logic/tcc_timer_cc.sv
// Capture/compare and one pulse section of a 16-bit timer
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Selected edge on capture pin copies counter into capture value.
// - Capture registers are read-only; writes leave them unchanged.
// - Capture sets flag; irq when enable set and cpu mask clear.
// - Capture flag clears after status read then low-byte access.
// - High-byte read blocks new capture data until low byte read.
// - Capture register holds value of most recent capture.
// - In halt, edge only arms; flag and data appear on wake.
// - Each timer tick outside halt and pwm mode compare; match sets flag, drives enabled pin.
// - Compare irq needs enable and clear mask; pins low in reset.
// - Compare registers read/write, hardware-untouched, reset 8000h.
// - Compare flag clears after status read then low-byte access.
// - High-byte write suspends compares until low byte written.
// - Force bit copies level to pin; no flag, no interrupt.
// - Force bits ignored in one pulse or pwm mode.
// - One pulse select uses capture one trigger, compare one end.
// - Trigger: counter FFFCh, pin gets level two, flag, FFFDh.
// - One pulse: counter equals compare one drives level one.
// - One pulse: compare flag one never set; flag two still works.
// - Both one pulse and pwm set: only pwm operates.
// - Equal levels in one pulse give constant pin level.
// - One pulse: pin one no capture; channel two captures normally.
// - One pulse: compare two flags time but drives no waveform.
// - Clock select: 00 div4, 01 div2, 10 div8, 11 external.
// - Edge select 0 falling, 1 rising.
module tcc_timer_cc (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [15:0] counter_i,
  input wire logic ext_tick_i,
  input wire logic halt_i,
  input wire logic cpu_irq_mask_i,
  input wire logic [1:0] capture_pin_i,
  output logic [1:0] compare_pin_o,
  output logic [1:0] compare_pin_enable_o,
  output logic timer_tick_o,
  output logic counter_load_o,
  output logic [15:0] counter_load_value_o,
  output logic irq_o
);
  import tcc_pkg::*;

  // Register state
  logic [7:0] ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d;
  logic [15:0] cmp_q [2], cmp_d [2];
  logic [1:0] cmp_susp_q, cmp_susp_d;
  logic [1:0] cmp_flag_q, cmp_flag_d;
  logic [1:0] pin_q, pin_d;
  tcc_cap_type cap_q [2], cap_d [2];
  logic [3:0] st_seen_q, st_seen_d;
  logic [2:0] div_q, div_d;
  logic [2:0] sync1_q [2], sync1_d [2];
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] lo_buf_q [2], lo_buf_d [2];

  // Derived modes; pwm wins over one pulse
  logic pwm_mode, opm_mode, tick;
  logic [1:0] edge_hit;
  logic wr, rd;
  assign pwm_mode = ctrl2_q[C2_PWM];
  assign opm_mode = ctrl2_q[C2_ONE_PULSE] & ~pwm_mode;
  assign wr = psel_i & penable_i & pwrite_i;
  assign rd = psel_i & penable_i & ~pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;

  // Edge test on agreeing later synchroniser stages
  function automatic logic edge_seen(input logic [2:0] s, input logic rise);
    edge_seen = rise ? (s[1] & s[2] & ~s[0]) : (~s[1] & ~s[2] & s[0]);
  endfunction

  // Timer tick from prescaler or external tick
  always_comb begin
    div_d = div_q + 3'h1;
    case (ctrl2_q[C2_CLK_HI:C2_CLK_LO])
      CLK_DIV4: tick = (div_q & DIV4_MASK) == DIV4_MASK;
      CLK_DIV2: tick = (div_q & DIV2_MASK) == DIV2_MASK;
      CLK_DIV8: tick = div_q == DIV8_MASK;
      CLK_EXT: tick = ext_tick_i;
      default: tick = 1'b0;
    endcase
  end

  // Three-stage pin synchroniser; stage0 unread except by stage1
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      sync1_d[i] = {sync1_q[i][1:0], capture_pin_i[i]};
      // Bit 2 oldest; compare stage1 (bit1) vs stage2 (bit2)
    end
  end
  // Edge on stages 1 and 2 differing: use bits shifted once more
  always_comb begin
    edge_hit[0] = edge_seen({sync1_q[0][2], sync1_q[0][2], sync1_q[0][1]},
                            ctrl1_q[C1_EDGE1]) & 1'b0;
    edge_hit[1] = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (i == 0) begin
        edge_hit[i] = (sync1_q[i][1] != sync1_q[i][2]) &&
          (sync1_q[i][1] == ctrl1_q[C1_EDGE1]);
      end else begin
        edge_hit[i] = (sync1_q[i][1] != sync1_q[i][2]) &&
          (sync1_q[i][1] == ctrl2_q[C2_EDGE2]);
      end
    end
  end

  // Register, capture, compare and pin next-state logic
  always_comb begin
    logic [7:0] wb;
    logic [3:0] st_now;
    wb = pwdata_i[7:0];
    st_now = {cap_q[0].flag, cmp_flag_q[0], cap_q[1].flag, cmp_flag_q[1]};
    ctrl1_d = ctrl1_q;
    ctrl2_d = ctrl2_q;
    cmp_d = cmp_q;
    cmp_susp_d = cmp_susp_q;
    cmp_flag_d = cmp_flag_q;
    pin_d = pin_q;
    cap_d = cap_q;
    st_seen_d = st_seen_q;
    lo_buf_d = lo_buf_q;
    rdata_d = 32'h0;
    counter_load_o = 1'b0;
    counter_load_value_o = CNT_TRIGGER;
    // Bus reads; status read arms the clear sequence
    if (rd) begin
      case (paddr_i)
        ADDR_CTRL1: rdata_d = {24'h0, ctrl1_q};
        ADDR_CTRL2: rdata_d = {24'h0, ctrl2_q};
        ADDR_STATUS: begin
          rdata_d = {24'h0, st_now[3:2], 1'b0, st_now[1:0], 3'h0};
          st_seen_d = st_seen_q | st_now;
        end
        ADDR_CAP1_HI: rdata_d = {24'h0, cap_q[0].value[15:8]};
        ADDR_CAP1_LO: rdata_d = {24'h0, cap_q[0].value[7:0]};
        ADDR_CAP2_HI: rdata_d = {24'h0, cap_q[1].value[15:8]};
        ADDR_CAP2_LO: rdata_d = {24'h0, cap_q[1].value[7:0]};
        ADDR_CMP1_HI: rdata_d = {24'h0, cmp_q[0][15:8]};
        ADDR_CMP1_LO: rdata_d = {24'h0, cmp_q[0][7:0]};
        ADDR_CMP2_HI: rdata_d = {24'h0, cmp_q[1][15:8]};
        ADDR_CMP2_LO: rdata_d = {24'h0, cmp_q[1][7:0]};
        default: rdata_d = 32'h0;
      endcase
    end
    // Capture high read locks the register until low read
    for (int i = 0; i < 2; i++) begin
      if (rd && paddr_i == (i == 0 ? ADDR_CAP1_HI : ADDR_CAP2_HI)) begin
        cap_d[i].locked = 1'b1;
      end
      if (rd && paddr_i == (i == 0 ? ADDR_CAP1_LO : ADDR_CAP2_LO)) begin
        cap_d[i].locked = 1'b0;
      end
      // Low access after status read clears flag; writes don't store
      if ((rd | wr) && paddr_i == (i == 0 ? ADDR_CAP1_LO : ADDR_CAP2_LO)
          && st_seen_q[i == 0 ? 3 : 1]) begin
        cap_d[i].flag = 1'b0;
        st_seen_d[i == 0 ? 3 : 1] = 1'b0;
      end
      if ((rd | wr) && paddr_i == (i == 0 ? ADDR_CMP1_LO : ADDR_CMP2_LO)
          && st_seen_q[i == 0 ? 2 : 0]) begin
        cmp_flag_d[i] = 1'b0;
        st_seen_d[i == 0 ? 2 : 0] = 1'b0;
      end
    end
    // Bus writes to control and compare registers
    if (wr) begin
      case (paddr_i)
        ADDR_CTRL1: ctrl1_d = wb;
        ADDR_CTRL2: ctrl2_d = wb;
        ADDR_CMP1_HI: begin
          cmp_d[0][15:8] = wb;
          cmp_susp_d[0] = 1'b1;
        end
        ADDR_CMP1_LO: begin
          cmp_d[0][7:0] = wb;
          cmp_susp_d[0] = 1'b0;
        end
        ADDR_CMP2_HI: begin
          cmp_d[1][15:8] = wb;
          cmp_susp_d[1] = 1'b1;
        end
        ADDR_CMP2_LO: begin
          cmp_d[1][7:0] = wb;
          cmp_susp_d[1] = 1'b0;
        end
        default: ;
      endcase
      // Force bits copy level immediately, never in special modes
      if (paddr_i == ADDR_CTRL1 && !opm_mode && !pwm_mode) begin
        if (wb[C1_FORCE1]) pin_d[0] = wb[C1_LVL1];
        if (wb[C1_FORCE2]) pin_d[1] = wb[C1_LVL2];
      end
    end
    // Capture edges; halt only arms, first halt edge kept
    for (int i = 0; i < 2; i++) begin
      if (edge_hit[i] && !(i == 0 && (opm_mode || pwm_mode))) begin
        if (halt_i) begin
          if (!cap_q[i].armed) begin
            cap_d[i].armed = 1'b1;
            cap_d[i].halt_value = counter_i;
          end
        end else begin
          cap_d[i].flag = 1'b1;
          if (!cap_d[i].locked) cap_d[i].value = counter_i;
        end
      end
      // Wake: armed capture shows flag and first-edge data
      if (!halt_i && cap_q[i].armed) begin
        cap_d[i].armed = 1'b0;
        cap_d[i].flag = 1'b1;
        if (!cap_d[i].locked) cap_d[i].value = cap_q[i].halt_value;
      end
    end
    // One pulse trigger on capture pin one
    if (opm_mode && edge_hit[0] && !halt_i) begin
      counter_load_o = 1'b1;
      pin_d[0] = ctrl1_q[C1_LVL2];
      cap_d[0].flag = 1'b1;
      if (!cap_d[0].locked) cap_d[0].value = CAP_TRIGGER;
    end
    // Compares on each timer tick outside halt and pwm mode; hardware never writes cmp_q
    if (tick && !halt_i && !pwm_mode) begin
      for (int i = 0; i < 2; i++) begin
        if (!cmp_susp_q[i] && cmp_q[i] == counter_i) begin
          if (!(i == 0 && opm_mode)) cmp_flag_d[i] = 1'b1;
          if (i == 0 && opm_mode) begin
            pin_d[0] = ctrl1_q[C1_LVL1];
          end else if (i == 1 && opm_mode) begin
            pin_d[1] = pin_q[1];
          end else if (ctrl2_q[i == 0 ? C2_PIN_EN1 : C2_PIN_EN2]) begin
            pin_d[i] = ctrl1_q[i == 0 ? C1_LVL1 : C1_LVL2];
          end
        end
      end
    end
  end

  // Single-register update for all state
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl1_q <= CTRL_RESET;
      ctrl2_q <= CTRL_RESET;
      cmp_q[0] <= CMP_RESET;
      cmp_q[1] <= CMP_RESET;
      cmp_susp_q <= 2'b00;
      cmp_flag_q <= 2'b00;
      pin_q <= 2'b00;
      cap_q[0] <= '0;
      cap_q[1] <= '0;
      st_seen_q <= 4'h0;
      div_q <= 3'h0;
      sync1_q[0] <= 3'h0;
      sync1_q[1] <= 3'h0;
      rdata_q <= 32'h0;
      lo_buf_q[0] <= 16'h0;
      lo_buf_q[1] <= 16'h0;
    end else begin
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      cmp_q <= cmp_d;
      cmp_susp_q <= cmp_susp_d;
      cmp_flag_q <= cmp_flag_d;
      pin_q <= pin_d;
      cap_q <= cap_d;
      st_seen_q <= st_seen_d;
      div_q <= div_d;
      sync1_q <= sync1_d;
      rdata_q <= rdata_d;
      lo_buf_q <= lo_buf_d;
    end
  end

  // Outputs; read data goes straight from decode since pready is 1
  always_comb begin
    prdata_o = rdata_d;
  end
  assign compare_pin_o = pin_q;
  assign compare_pin_enable_o = {ctrl2_q[C2_PIN_EN2], ctrl2_q[C2_PIN_EN1]};
  assign timer_tick_o = tick;
  // Level interrupt; cpu mask holds it pending
  assign irq_o = ~cpu_irq_mask_i &
    ((ctrl1_q[C1_CAP_IE] & (cap_q[0].flag | cap_q[1].flag)) |
     (ctrl1_q[C1_CMP_IE] & (|cmp_flag_q)));

  // Assertions
  property p_cmp_reset;
    @(posedge clk_i) disable iff (!reset_n_i)
    $rose(reset_n_i) |-> cmp_q[0] == CMP_RESET;
  endproperty
  a_cmp_reset: assert property (p_cmp_reset) else $error("cmp reset");
  property p_opm_no_flag1;
    @(posedge clk_i) disable iff (!reset_n_i)
    (opm_mode && !cmp_flag_q[0]) |=> !cmp_flag_q[0] || !$past(opm_mode);
  endproperty
  a_opm_no_flag1: assert property (p_opm_no_flag1) else $error("opm flag1");
  property p_capture;
    @(posedge clk_i) disable iff (!reset_n_i)
    (edge_hit[1] && !halt_i && !cap_q[1].locked && !(rd && paddr_i ==
      ADDR_CAP2_LO)) |=> cap_q[1].value == $past(counter_i) && cap_q[1].flag;
  endproperty
  a_capture: assert property (p_capture) else $error("capture");
  property p_halt;
    @(posedge clk_i) disable iff (!reset_n_i)
    (halt_i && !cap_q[1].flag) |=> !cap_q[1].flag;
  endproperty
  a_halt: assert property (p_halt) else $error("halt flag");
  property p_trigger;
    @(posedge clk_i) disable iff (!reset_n_i)
    (opm_mode && edge_hit[0] && !halt_i) |=> pin_q[0] == $past(ctrl1_q[2]);
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger");
  property p_susp;
    @(posedge clk_i) disable iff (!reset_n_i)
    (cmp_susp_q[1] && !cmp_flag_q[1] && !wr) |=> !cmp_flag_q[1];
  endproperty
  a_susp: assert property (p_susp) else $error("suspend");
  property p_irq;
    @(posedge clk_i) disable iff (!reset_n_i)
    cpu_irq_mask_i |-> !irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq mask");
  property p_lock;
    @(posedge clk_i) disable iff (!reset_n_i)
    (cap_q[1].locked && !(rd && paddr_i == ADDR_CAP2_LO)) |=>
      $stable(cap_q[1].value);
  endproperty
  a_lock: assert property (p_lock) else $error("lock");
  c_capture: cover property (@(posedge clk_i) edge_hit[1] && !halt_i);
  c_opm: cover property (@(posedge clk_i) opm_mode && edge_hit[0]);
  c_match: cover property (@(posedge clk_i) $rose(cmp_flag_q[1]));
endmodule
`default_nettype wire
